/* phy_status_irq_enable_regs.sv */
// status summary, interrupt enable, pending flags and interrupt pin
// assumes status and event inputs come from logic on clk_i
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "phy_regs_defines.svh"

module phy_status_irq_enable_regs (
  input wire logic clk_i, // 250 MHz core clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lane selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire phy_regs_pkg::link_summary_t status_i, // live status
  input wire phy_regs_pkg::irq_events_t event_i, // event pulses
  output logic irq_pin_o // interrupt pin, polarity programmable
);

  logic ack_ff;
  logic [31:0] rd_ff;
  phy_regs_pkg::link_summary_t status_ff;
  logic page_ff;
  logic [15:0] mask_ff;
  logic [15:0] pend_ff;
  logic [15:0] cfg_ff;
  logic irq_ff;
  logic req;
  logic rd_hit;
  logic wr_hit;
  logic [5:0] idx;
  logic [15:0] events;
  logic [15:0] status_word;
  logic any_pending;

  // merge byte lanes 0 and 1 into a 16-bit register
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_v,
    input logic [31:0] dat,
    input logic [3:0] sel,
    input logic [15:0] writable
  );
    logic [15:0] v;
    v = old_v;
    if (sel[0])
    begin
      v[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      v[15:8] = dat[15:8];
    end
    lane_merge = (v & writable) | (old_v & ~writable);
  endfunction

  // a single-wait-state answer: ack rises one edge after the strobe
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign idx = wb_adr_i[7:2];
  assign rd_hit = req & ~wb_we_i;
  assign wr_hit = req & wb_we_i;
  assign events = event_i;

  // page bit comes from its latch, everything else is the live copy
  always_comb
  begin
    status_word = status_ff;
    status_word[`LSS_PAGE_BIT] = page_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req;
    end
  end

  // unmapped words read zero and ignore writes, but are still acked
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_ff <= 32'h0000_0000;
    end
    else if (rd_hit)
    begin
      unique case (idx)
        `IDX_LINK_STATUS_SUMMARY: rd_ff <= {16'h0000, status_word};
        `IDX_INTERRUPT_ENABLE_MASK: rd_ff <= {16'h0000, mask_ff};
        `IDX_INTERRUPT_PENDING_FLAGS: rd_ff <= {16'h0000, pend_ff};
        `IDX_SECOND_CONFIG_WORD: rd_ff <= {16'h0000, cfg_ff};
        default: rd_ff <= 32'h0000_0000;
      endcase
    end
  end

  // live status sampled each cycle; polarity bit resets to correct
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_ff <= `LSS_RESET;
    end
    else
    begin
      status_ff <= status_i;
    end
  end

  // set wins over the clear of a simultaneous status read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      page_ff <= 1'b0;
    end
    else if (event_i.page_received)
    begin
      page_ff <= 1'b1;
    end
    else if (rd_hit && idx == `IDX_LINK_STATUS_SUMMARY)
    begin
      page_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_ff <= `IEM_RESET;
    end
    else if (wr_hit && idx == `IDX_INTERRUPT_ENABLE_MASK)
    begin
      mask_ff <= lane_merge(mask_ff, wb_dat_i, wb_sel_i, `IEM_WRITABLE);
    end
  end

  // flags latch regardless of enables; a read clears, new events win
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_ff <= `IPF_RESET;
    end
    else if (rd_hit && idx == `IDX_INTERRUPT_PENDING_FLAGS)
    begin
      pend_ff <= events & `IEM_WRITABLE;
    end
    else
    begin
      pend_ff <= pend_ff | (events & `IEM_WRITABLE);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_ff <= `SCW_RESET;
    end
    else if (wr_hit && idx == `IDX_SECOND_CONFIG_WORD)
    begin
      cfg_ff <= lane_merge(cfg_ff, wb_dat_i, wb_sel_i, `SCW_WRITABLE);
    end
  end

  assign any_pending = |(pend_ff & mask_ff);

  // registered pin so it never glitches while flags settle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_ff <= 1'b1; // inactive level for the default active-low pin
    end
    else
    begin
      irq_ff <= any_pending ^ cfg_ff[`SCW_IRQ_POLARITY_BIT];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;
  assign irq_pin_o = irq_ff;

endmodule // phy_status_irq_enable_regs

`default_nettype wire

/* phy_regs_defines.svh */
// register offsets, field positions, reset values and masks for the
// transceiver status and interrupt-enable register bank
// assumes a wishbone slave with 32-bit data, one register per word
`ifndef PHY_REGS_DEFINES_SVH
`define PHY_REGS_DEFINES_SVH

`define IDX_LINK_STATUS_SUMMARY 6'h11
`define IDX_INTERRUPT_ENABLE_MASK 6'h12
`define IDX_INTERRUPT_PENDING_FLAGS 6'h13
`define IDX_SECOND_CONFIG_WORD 6'h14

`define LSS_RESET 16'h0002
`define LSS_PAGE_BIT 12
`define IEM_RESET 16'h0000
`define IEM_WRITABLE 16'hfd7f
`define IPF_RESET 16'h0000
`define SCW_RESET 16'h2000
`define SCW_WRITABLE 16'h2000
`define SCW_IRQ_POLARITY_BIT 13

`endif

/* phy_regs_pkg.sv */
// types shared by the status and interrupt-enable register bank
// assumes nothing beyond the defines header
package phy_regs_pkg;

  // laid out exactly as the status word reads
  typedef struct packed {
    logic [1:0] resolved_rate_code;
    logic full_duplex;
    logic page_seen;
    logic resolved;
    logic link_up;
    logic pairs_cd_crossover_flag;
    logic pairs_ab_crossover_flag;
    logic downshift_active_flag;
    logic sleeping;
    logic [3:0] channel_polarity_flags;
    logic pol10_correct;
    logic jabber;
  } link_summary_t;

  // one-cycle event pulses, laid out as the enable mask
  typedef struct packed {
    logic negotiation_fault;
    logic rate_change;
    logic duplex_change;
    logic page_received;
    logic negotiation_done;
    logic link_change;
    logic rsvd9;
    logic false_carrier;
    logic rsvd7;
    logic crossover_change;
    logic downshift_event;
    logic sleep_change;
    logic wake_packet;
    logic mac_if_error;
    logic polarity_change;
    logic jabber;
  } irq_events_t;

endpackage

/* phy_status_irq_enable_regs_sva.sv */
// checker for the status and interrupt-enable register bank
// assumes a bind onto the top module ports
`timescale 1ns/1ps
`default_nettype none
module phy_status_irq_enable_regs_sva (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire phy_regs_pkg::link_summary_t status_i, // status
  input wire phy_regs_pkg::irq_events_t event_i // events
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  sequence s_rd_sts;
    take && !wb_we_i && wb_adr_i == 8'h44;
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_latency: assert property (take |=> wb_ack_o)
    else $error("ack late");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
    else $error("ack without request");
  a_status_copy: assert property (s_rd_sts |=>
    (wb_dat_o[15:0] & 16'hefff) == ($past(status_i, 2) & 16'hefff))
    else $error("status word wrong");
  a_page_latch: assert property (
    event_i.page_received ##1 s_rd_sts |=> wb_dat_o[12])
    else $error("page flag lost");
  a_rsvd_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h48 |-> !wb_dat_o[9] && !wb_dat_o[7])
    else $error("reserved enable bit set");
  a_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[7:6] != 2'b01 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved");
endmodule // phy_status_irq_enable_regs_sva
`default_nettype wire

/* phy_status_irq_enable_regs_tb.sv */
// self-checking bench for the status and interrupt-enable register bank
// assumes one-cycle acks and the polarity bit at byte address 0x50
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH %0t got %h", $time, a); end end
module phy_status_irq_enable_regs_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, wb_dat_o;
  logic wb_ack_o, irq_pin_o;
  logic [15:0] sts = 16'h0, ev = 16'h0, e, q[$];
  int err_total = 0, checked = 0, n = 0, i;
  always #2 clk_i = ~clk_i;
  phy_status_irq_enable_regs i_phy_status_irq_enable_regs (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .status_i(sts), .event_i(ev),
    .irq_pin_o(irq_pin_o));
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [15:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, 16'h0, d, s};
    ev <= 16'h0;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    q.push_back(x);
    bus(1'b0, a, 16'h0, 4'hf);
  endtask
  task automatic ping(input logic [15:0] x);
    @(posedge clk_i);
    ev <= x;
    @(posedge clk_i);
    ev <= 16'h0;
    repeat (2) @(posedge clk_i);
  endtask
  task tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // the reader side: every ack of a read takes the oldest expectation
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && !we)
      `CK(wb_dat_o[15:0], q.pop_front())
  always @(posedge clk_i)
  begin
    n++;
    if (n == 3000)
    begin
      err_total++;
      tally_and_finish;
    end
  end
  initial
  begin
    void'($urandom(22));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h48, 16'h0);
    rd(8'h4c, 16'h0);
    rd(8'hfc, 16'h0);
    `CK(irq_pin_o, 1'b1)
    $display("reset test end");
    for (i = 0; i < 8; i++)
    begin
      sts <= 16'($urandom()) & 16'hefff;
      @(posedge clk_i);
      rd(8'h44, sts);
    end
    @(posedge clk_i);
    ev <= 16'h1000;
    rd(8'h44, sts | 16'h1000);
    rd(8'h44, sts);
    // the page event also left its pending flag; clear it before irq tests
    rd(8'h4c, 16'h1000);
    $display("status test end");
    bus(1'b1, 8'h48, 16'hffff, 4'hf);
    rd(8'h48, 16'hfd7f);
    bus(1'b1, 8'h48, 16'h0, 4'h1);
    rd(8'h48, 16'hfd00);
    for (i = 0; i < 16; i++)
      if (i != 7 && i != 9)
      begin
        e = 16'h1 << i;
        // all other sources on, so only a wrong mask bit can fire the pin
        bus(1'b1, 8'h48, ~e, 4'hf);
        ping(e);
        `CK(irq_pin_o, 1'b1)
        rd(8'h4c, e);
        bus(1'b1, 8'h48, e, 4'hf);
        ping(e);
        `CK(irq_pin_o, 1'b0)
        rd(8'h4c, e);
        repeat (2) @(posedge clk_i);
        `CK(irq_pin_o, 1'b1)
      end
    bus(1'b1, 8'h50, 16'h0, 4'hf);
    repeat (2) @(posedge clk_i);
    `CK(irq_pin_o, 1'b0)
    ping(16'h8000);
    `CK(irq_pin_o, 1'b1)
    rd(8'h50, 16'h0);
    $display("interrupt test end");
    tally_and_finish;
  end
endmodule // phy_status_irq_enable_regs_tb
bind phy_status_irq_enable_regs phy_status_irq_enable_regs_sva i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .status_i(status_i), .event_i(event_i));
`default_nettype wire
